/* peripheral_id_and_pin_mux_tb.sv */
// Self-checking bench for pidm_top: registers, decode, gating, pads.
// Assumes the peripheral model and the bound checker are compiled first.
module peripheral_id_and_pin_mux_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, arst_n, reg_wr, reg_rd, sys_req, fast_irq_pin, conv_req, conv_done, rd_d;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, sys_addr, v;
    logic [6:0]  sys_irq;
    logic [26:0] periph_irq;
    logic [2:0]  ext_irq_pin;
    logic [95:0] prev_a, prev_b, prev_boe;
    wire  [31:0] reg_rdata_q, irq_src_q, periph_clk_en_q;
    wire  [11:0] slice_sel_q;
    wire         slice_miss_q, evt_irq_q;
    wire  [95:0] fa_out, fa_oe, fb_out, fb_oe, pad_out_q, pad_oe_q, pad_pullup_q, fa_in, fb_in;
    wire  [95:0] pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & pad_pullup_q);
    logic [31:0] exp_q[$];
    int          err_count, total_checks, i;

    pidm_top uut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .evt_irq_q(evt_irq_q),
        .sys_addr(sys_addr), .sys_req(sys_req), .slice_sel_q(slice_sel_q), .slice_miss_q(slice_miss_q),
        .sys_irq(sys_irq), .periph_irq(periph_irq), .fast_irq_pin(fast_irq_pin), .ext_irq_pin(ext_irq_pin),
        .irq_src_q(irq_src_q), .periph_clk_en_q(periph_clk_en_q), .conv_req(conv_req), .conv_done(conv_done),
        .func_a_out(fa_out), .func_a_oe(fa_oe), .func_b_out(fb_out), .func_b_oe(fb_oe), .func_a_in_q(fa_in),
        .func_b_in_q(fb_in), .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
        .pad_pullup_q(pad_pullup_q));
    pidm_periph_model u_model (.core_clk(core_clk), .arst_n(arst_n), .func_a_out(fa_out),
        .func_a_oe(fa_oe), .func_b_out(fb_out), .func_b_oe(fb_oe));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic dec(input logic [31:0] a, input logic [12:0] e);
        @(posedge core_clk);
        sys_req  <= 1'b1;
        sys_addr <= a;
        @(posedge core_clk);
        sys_req <= 1'b0;
        #1 chk(32'({slice_miss_q, slice_sel_q}), 32'(e));
    endtask
    task automatic test_done;
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk) begin
        rd_d     <= reg_rd;
        prev_a   <= fa_out;
        prev_b   <= fb_out;
        prev_boe <= fb_oe;
        if (rd_d === 1'b1)
            chk(reg_rdata_q, exp_q.pop_front());
    end
    initial begin
        #100000;
        err_count++;
        test_done;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, sys_req, fast_irq_pin, conv_req, conv_done} = '0;
        reg_addr = '0;
        {reg_wdata, sys_addr, sys_irq, periph_irq, ext_irq_pin} = '0;
        err_count = 0;
        total_checks = 0;
        v = $urandom(75001);
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(8'h08, 32'h00000002);
        rd(8'h48, 32'h00000000);
        rd(8'h88, 32'h00000430);
        rd(8'h98, 32'hFFFFFFFF);
        rd(8'hFC, 32'h00000000);
        for (i = 0; i < 12; i++)
            dec(32'hFFFA0000 + (i << 14) + ($urandom & 32'h3FFF), 13'(1 << i));
        dec(32'hFFF9FFFC, 13'h1000);
        dec(32'hFFFD0000, 13'h1000);
        rd(8'h18, 32'h00000000);
        rd(8'h0C, 32'h00000001);
        wr(8'h10, 32'h00000002);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h08, 32'h1FEFFFDE);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h08, 32'h00000002);
        rd(8'h10, 32'h00000002);
        #1 chk(32'(evt_irq_q), 32'h1);
        rd(8'h0C, 32'h00000002);
        repeat (2) @(posedge core_clk);
        #1 chk(32'(evt_irq_q), 32'h0);
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h0 : $urandom;
            @(posedge core_clk);
            sys_irq      <= v[6:0];
            periph_irq   <= v[31:5];
            ext_irq_pin  <= v[2:0];
            fast_irq_pin <= v[3];
            repeat (4) @(posedge core_clk);
            #1 chk(irq_src_q, {v[2:0], v[31:5], |v[6:0], v[3]});
        end
        wr(8'h14, 32'h00000001);
        @(posedge core_clk);
        conv_req <= 1'b1;
        @(posedge core_clk);
        conv_req <= 1'b0;
        #1 chk(32'(periph_clk_en_q[5]), 32'h1);
        rd(8'h14, 32'h00000003);
        @(posedge core_clk);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk(periph_clk_en_q, 32'h00000002);
        rd(8'h0C, 32'h00000004);
        wr(8'h40, 32'h00000003);
        wr(8'h4C, 32'h00000002);
        wr(8'h60, 32'h00000001);
        rd(8'h48, 32'h00000003);
        rd(8'h68, 32'h00000001);
        rd(8'h4C, 32'h00000002);
        #1 chk(32'({pad_oe_q[1], pad_out_q[1:0]}), 32'({prev_boe[1], prev_b[1], prev_a[0]}));
        chk(32'(pad_out_q[32]), 32'(prev_a[0]));
        chk(32'({fa_in[2], fb_in[0]}), 32'h3);
        wr(8'h44, 32'h00000001);
        rd(8'h48, 32'h00000002);
        repeat (2) @(posedge core_clk);
        test_done;
    end
endmodule

/* pidm_periph_model.sv */
// Stand-in for the on-chip peripherals that drive functions A and B.
// Assumes core_clk and arst_n of the glue.
module pidm_periph_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Function drive per line
    output wire logic [95:0] func_a_out,
    output wire logic [95:0] func_a_oe,
    output wire logic [95:0] func_b_out,
    output wire logic [95:0] func_b_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [95:0] pat_q;
    // Moves every cycle so a stale copy never matches by luck
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            pat_q <= 96'h0;
        else
            pat_q <= {pat_q[94:0], ~pat_q[95] ^ pat_q[40]};
    end
    // One output-only function offered on two controllers
    assign func_a_out = {pat_q[95:33], pat_q[0], pat_q[31:0]};
    assign func_a_oe  = {96{1'b1}};
    assign func_b_out = ~pat_q;
    assign func_b_oe  = {pat_q[47:0], pat_q[95:48]};
endmodule

/* pidm_regs.vh */
// Constants for the peripheral identifier and pin multiplexing glue.
// Assumes byte addresses on the register port, one 32-bit word per register.
`ifndef PIDM_REGS_VH
`define PIDM_REGS_VH

// Peripheral address window and slicing
`define PIDM_WIN_LO        32'hFFFA0000
`define PIDM_WIN_HI        32'hFFFCFFFF
`define PIDM_SLICE_SHIFT   14
`define PIDM_NUM_SLICES    12

// Peripheral identifiers with special handling
`define PIDM_ID_FAST       0
`define PIDM_ID_SYS        1
`define PIDM_ID_CONV       5
`define PIDM_ID_EXT0       29
// Identifiers whose clock bits ignore writes: 0, 1, 5, 20, 29, 30, 31
`define PIDM_CLK_FIXED     32'hE0100023
// Group merged on source 1 keeps its clock running
`define PIDM_CLK_ALWAYS    32'h00000002

// Register offsets
`define PIDM_CLK_SET       8'h00
`define PIDM_CLK_CLR       8'h04
`define PIDM_CLK_STAT      8'h08
`define PIDM_EVT_STAT      8'h0C
`define PIDM_EVT_MASK      8'h10
`define PIDM_CONV_CTRL     8'h14
`define PIDM_DEC_STAT      8'h18
`define PIDM_SRC_STAT      8'h1C
// Per controller block: base + stride * index
`define PIDM_PIO_BLK0      3'h2
`define PIDM_PIO_FUNC_EN   5'h00
`define PIDM_PIO_GPIO_EN   5'h04
`define PIDM_PIO_FUNC_ST   5'h08
`define PIDM_PIO_SEL_B     5'h0C
`define PIDM_PIO_OUT       5'h10
`define PIDM_PIO_OE        5'h14
`define PIDM_PIO_PULLUP    5'h18
`define PIDM_PIO_LEVEL     5'h1C

// Event bits
`define PIDM_EV_MISS       0
`define PIDM_EV_CLKIGN     1
`define PIDM_EV_CONVSTOP   2
`define PIDM_EV_W          3

// Reset values
`define PIDM_PULLUP_RST    32'hFFFFFFFF
`define PIDM_SELB_RST      32'h00000000
`define PIDM_FUNC_RST_A    32'h00000000
`define PIDM_FUNC_RST_B    32'h00000000
`define PIDM_FUNC_RST_C    32'h00000430

`endif

/* pidm_top.v */
// Peripheral identifier, address slice decode, clock gating and pin mux.
// Assumes one clock domain; pad and external interrupt pins are asynchronous.
`include "pidm_regs.vh"

module pidm_top #(
    parameter NUM_CTL    = 3,
    parameter NUM_LINES  = 32,
    parameter FUNC_RST_A = `PIDM_FUNC_RST_A,
    parameter FUNC_RST_B = `PIDM_FUNC_RST_B,
    parameter FUNC_RST_C = `PIDM_FUNC_RST_C
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         arst_n,
    // Register port
    input  wire [7:0]   reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [31:0]  reg_rdata_q,
    output reg          evt_irq_q,
    // System address decode
    input  wire [31:0]  sys_addr,
    input  wire         sys_req,
    output reg  [11:0]  slice_sel_q,
    output reg          slice_miss_q,
    // Interrupt sources and clock gates
    input  wire [6:0]   sys_irq,
    input  wire [26:0]  periph_irq,
    input  wire         fast_irq_pin,
    input  wire [2:0]   ext_irq_pin,
    output reg  [31:0]  irq_src_q,
    output reg  [31:0]  periph_clk_en_q,
    // Converter clock control
    input  wire         conv_req,
    input  wire         conv_done,
    // Peripheral side of the lines
    input  wire [95:0]  func_a_out,
    input  wire [95:0]  func_a_oe,
    input  wire [95:0]  func_b_out,
    input  wire [95:0]  func_b_oe,
    output reg  [95:0]  func_a_in_q,
    output reg  [95:0]  func_b_in_q,
    // Package lines
    input  wire [95:0]  pad_in,
    output reg  [95:0]  pad_out_q,
    output reg  [95:0]  pad_oe_q,
    output reg  [95:0]  pad_pullup_q
);

    localparam NL = NUM_CTL * NUM_LINES;

    // Software clock enables and converter clock
    reg  [31:0]         clk_en_q;
    reg                 conv_clk_q;
    reg                 conv_sleep_q;
    // Event status and mask
    reg  [`PIDM_EV_W-1:0] evt_stat_q;
    reg  [`PIDM_EV_W-1:0] evt_mask_q;
    reg  [`PIDM_EV_W-1:0] evt_set;
    reg  [`PIDM_EV_W-1:0] evt_stat_d;
    // Last decode result for software
    reg  [4:0]          dec_last_q;
    // Line configuration
    reg  [NL-1:0]       func_q;
    reg  [NL-1:0]       selb_q;
    reg  [NL-1:0]       gout_q;
    reg  [NL-1:0]       goe_q;
    reg  [NL-1:0]       pull_q;
    // Synchronisers
    reg  [NL-1:0]       pad_s1_q;
    reg  [NL-1:0]       pad_s2_q;
    reg  [3:0]          ext_s1_q;
    reg  [3:0]          ext_s2_q;

    wire [2:0]          blk = reg_addr[7:5];
    wire [4:0]          sub = reg_addr[4:0];
    wire                in_win;
    wire [31:0]         win_off;
    wire [3:0]          slice_idx;
    wire [31:0]         clk_wr_mask;

    assign in_win      = (sys_addr >= `PIDM_WIN_LO) && (sys_addr <= `PIDM_WIN_HI);
    assign win_off     = sys_addr - `PIDM_WIN_LO;
    assign slice_idx   = win_off[`PIDM_SLICE_SHIFT+3:`PIDM_SLICE_SHIFT];
    assign clk_wr_mask = reg_wdata & ~`PIDM_CLK_FIXED;

    // Address window decode, one registered cycle
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            slice_sel_q  <= 12'h000;
            slice_miss_q <= 1'b0;
            dec_last_q   <= 5'h00;
        end else begin
            slice_sel_q  <= 12'h000;
            slice_miss_q <= sys_req && !in_win;
            if (sys_req && in_win) begin
                slice_sel_q[slice_idx] <= 1'b1;
                dec_last_q             <= {1'b1, slice_idx};
            end else if (sys_req) begin
                dec_last_q <= 5'h00;
            end
        end
    end

    // Asynchronous pins: first stage feeds only the second
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_s1_q <= {NL{1'b0}};
            pad_s2_q <= {NL{1'b0}};
            ext_s1_q <= 4'h0;
            ext_s2_q <= 4'h0;
        end else begin
            pad_s1_q <= pad_in;
            pad_s2_q <= pad_s1_q;
            ext_s1_q <= {ext_irq_pin, fast_irq_pin};
            ext_s2_q <= ext_s1_q;
        end
    end

    // Interrupt sources by identifier
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_src_q <= 32'h00000000;
        end else begin
            irq_src_q[`PIDM_ID_FAST]                 <= ext_s2_q[0];
            irq_src_q[`PIDM_ID_SYS]                  <= |sys_irq;
            irq_src_q[28:2]                          <= periph_irq;
            irq_src_q[`PIDM_ID_EXT0+2:`PIDM_ID_EXT0] <= ext_s2_q[3:1];
        end
    end

    // Clock gates; fixed bits never take a write
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_en_q <= 32'h00000000;
        end else if (reg_wr && reg_addr == `PIDM_CLK_SET) begin
            clk_en_q <= clk_en_q | clk_wr_mask;
        end else if (reg_wr && reg_addr == `PIDM_CLK_CLR) begin
            clk_en_q <= clk_en_q & ~clk_wr_mask;
        end
    end

    // Converter clock: a new request beats a stop in the same cycle
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_clk_q <= 1'b0;
        end else if (conv_req) begin
            conv_clk_q <= 1'b1;
        end else if (conv_done && conv_sleep_q) begin
            conv_clk_q <= 1'b0;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_clk_en_q <= 32'h00000000;
        end else begin
            periph_clk_en_q                <= clk_en_q | `PIDM_CLK_ALWAYS;
            periph_clk_en_q[`PIDM_ID_CONV] <= conv_clk_q | conv_req;
        end
    end

    // Sticky events; a read clears but a same-cycle event survives
    always @* begin
        evt_set                    = {`PIDM_EV_W{1'b0}};
        evt_set[`PIDM_EV_MISS]     = sys_req && !in_win;
        evt_set[`PIDM_EV_CLKIGN]   = reg_wr && (reg_addr == `PIDM_CLK_SET || reg_addr == `PIDM_CLK_CLR)
                                     && |(reg_wdata & `PIDM_CLK_FIXED);
        evt_set[`PIDM_EV_CONVSTOP] = conv_done && conv_sleep_q && !conv_req;
        evt_stat_d                 = evt_stat_q;
        if (reg_rd && reg_addr == `PIDM_EVT_STAT)
            evt_stat_d = {`PIDM_EV_W{1'b0}};
        evt_stat_d = evt_stat_d | evt_set;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_stat_q   <= {`PIDM_EV_W{1'b0}};
            evt_mask_q   <= {`PIDM_EV_W{1'b0}};
            conv_sleep_q <= 1'b0;
            evt_irq_q    <= 1'b0;
        end else begin
            evt_stat_q <= evt_stat_d;
            evt_irq_q  <= |(evt_stat_d & evt_mask_q);
            if (reg_wr && reg_addr == `PIDM_EVT_MASK)
                evt_mask_q <= reg_wdata[`PIDM_EV_W-1:0];
            if (reg_wr && reg_addr == `PIDM_CONV_CTRL)
                conv_sleep_q <= reg_wdata[0];
        end
    end

    // Line configuration registers
    integer c;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            func_q <= {FUNC_RST_C, FUNC_RST_B, FUNC_RST_A};
            selb_q <= {NUM_CTL{`PIDM_SELB_RST}};
            gout_q <= {NL{1'b0}};
            goe_q  <= {NL{1'b0}};
            pull_q <= {NUM_CTL{`PIDM_PULLUP_RST}};
        end else begin
            for (c = 0; c < NUM_CTL; c = c + 1) begin
                if (reg_wr && blk == `PIDM_PIO_BLK0 + c[2:0]) begin
                    case (sub)
                        `PIDM_PIO_FUNC_EN: begin
                            func_q[c*NUM_LINES +: NUM_LINES] <=
                                func_q[c*NUM_LINES +: NUM_LINES] | reg_wdata;
                        end
                        `PIDM_PIO_GPIO_EN: begin
                            func_q[c*NUM_LINES +: NUM_LINES] <=
                                func_q[c*NUM_LINES +: NUM_LINES] & ~reg_wdata;
                        end
                        `PIDM_PIO_SEL_B: begin
                            selb_q[c*NUM_LINES +: NUM_LINES] <= reg_wdata;
                        end
                        `PIDM_PIO_OUT: begin
                            gout_q[c*NUM_LINES +: NUM_LINES] <= reg_wdata;
                        end
                        `PIDM_PIO_OE: begin
                            goe_q[c*NUM_LINES +: NUM_LINES] <= reg_wdata;
                        end
                        `PIDM_PIO_PULLUP: begin
                            pull_q[c*NUM_LINES +: NUM_LINES] <= reg_wdata;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Pad drive; one peripheral output may reach several lines at once
    integer i;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_out_q    <= {NL{1'b0}};
            pad_oe_q     <= {NL{1'b0}};
            pad_pullup_q <= {NL{1'b1}};
            func_a_in_q  <= {NL{1'b1}};
            func_b_in_q  <= {NL{1'b1}};
        end else begin
            pad_pullup_q <= pull_q;
            for (i = 0; i < NL; i = i + 1) begin
                // Idle level high on unselected inputs so peripherals see a quiet line
                func_a_in_q[i] <= (func_q[i] && !selb_q[i]) ? pad_s2_q[i] : 1'b1;
                func_b_in_q[i] <= (func_q[i] && selb_q[i]) ? pad_s2_q[i] : 1'b1;
                if (!func_q[i]) begin
                    pad_out_q[i] <= gout_q[i];
                    pad_oe_q[i]  <= goe_q[i];
                end else if (selb_q[i]) begin
                    pad_out_q[i] <= func_b_out[i];
                    pad_oe_q[i]  <= func_b_oe[i];
                end else begin
                    pad_out_q[i] <= func_a_out[i];
                    pad_oe_q[i]  <= func_a_oe[i];
                end
            end
        end
    end

    // Read mux; data stands the cycle after the strobe
    reg [31:0] rd_d;
    integer k;
    always @* begin
        rd_d = 32'h00000000;
        k    = 0;
        case (reg_addr)
            `PIDM_CLK_STAT:  rd_d = periph_clk_en_q;
            `PIDM_EVT_STAT:  rd_d[`PIDM_EV_W-1:0] = evt_stat_q;
            `PIDM_EVT_MASK:  rd_d[`PIDM_EV_W-1:0] = evt_mask_q;
            `PIDM_CONV_CTRL: rd_d = {30'h00000000, conv_clk_q, conv_sleep_q};
            `PIDM_DEC_STAT:  rd_d[4:0] = dec_last_q;
            `PIDM_SRC_STAT:  rd_d = irq_src_q;
            default: begin
                if (blk >= `PIDM_PIO_BLK0 && blk < `PIDM_PIO_BLK0 + NUM_CTL) begin
                    k = blk - `PIDM_PIO_BLK0;
                    case (sub)
                        `PIDM_PIO_FUNC_ST: rd_d = func_q[k*NUM_LINES +: NUM_LINES];
                        `PIDM_PIO_SEL_B:   rd_d = selb_q[k*NUM_LINES +: NUM_LINES];
                        `PIDM_PIO_OUT:     rd_d = gout_q[k*NUM_LINES +: NUM_LINES];
                        `PIDM_PIO_OE:      rd_d = goe_q[k*NUM_LINES +: NUM_LINES];
                        `PIDM_PIO_PULLUP:  rd_d = pull_q[k*NUM_LINES +: NUM_LINES];
                        `PIDM_PIO_LEVEL:   rd_d = pad_s2_q[k*NUM_LINES +: NUM_LINES];
                        default:           rd_d = 32'h00000000;
                    endcase
                end
            end
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule

/* pidm_top_asserts.sv */
// Checker for the identifier and pin mux glue, bound to pidm_top.
// Assumes one core_clk domain and arst_n active low.
module pidm_top_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // Decode and sources
    input wire logic [31:0] sys_addr,
    input wire logic        sys_req,
    input wire logic [11:0] slice_sel_q,
    input wire logic        slice_miss_q,
    input wire logic [6:0]  sys_irq,
    input wire logic [31:0] irq_src_q,
    input wire logic [31:0] periph_clk_en_q,
    input wire logic        conv_req,
    // Lines
    input wire logic [95:0] func_a_out,
    input wire logic [95:0] func_a_oe,
    input wire logic [95:0] pad_out_q,
    input wire logic [95:0] pad_oe_q,
    input wire logic [95:0] pad_pullup_q
);
    wire        in_win  = (sys_addr >= 32'hFFFA0000) && (sys_addr <= 32'hFFFCFFFF);
    wire [31:0] off_w   = sys_addr - 32'hFFFA0000;
    wire [3:0]  slc_w   = off_w[17:14];
    wire        sys_any = |sys_irq;
    // Controller C lines that leave reset on a memory function
    wire [5:0]  mem_drv = {func_a_out[74], func_a_out[69], func_a_out[68],
                           func_a_oe[74], func_a_oe[69], func_a_oe[68]};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_hit;
        sys_req && in_win;
    endsequence
    sequence s_miss;
        sys_req && !in_win;
    endsequence
    AST_DEC_MISS: assert property (s_miss |=> slice_miss_q && slice_sel_q == 12'h000)
        else $error("outside request not flagged");
    AST_DEC_SLICE: assert property (s_hit |=> !slice_miss_q && slice_sel_q == 12'h001 << $past(slc_w))
        else $error("wrong slice selected");
    AST_SYS_CLK_ON: assert property ($past(arst_n) |-> periph_clk_en_q[1])
        else $error("system group clock off");
    AST_FIXED_CLK_OFF: assert property ((periph_clk_en_q & 32'hE0100001) == 32'h0)
        else $error("ungated identifier shows a clock");
    AST_SRC_ONE: assert property ($past(arst_n) |-> irq_src_q[1] == $past(sys_any))
        else $error("source 1 not the OR of system requests");
    AST_CONV_START: assert property (conv_req |=> periph_clk_en_q[5])
        else $error("converter clock did not start");
    AST_MEM_DRIVE: assert property ($past(arst_n) |->
        {pad_out_q[74], pad_out_q[69], pad_out_q[68], pad_oe_q[74], pad_oe_q[69], pad_oe_q[68]}
        == $past(mem_drv))
        else $error("memory line not driven by its function");
    AST_PULLUP_ON: assert property (pad_pullup_q == {96{1'b1}})
        else $error("pull-up missing");
endmodule

bind pidm_top pidm_top_asserts u_chk (.core_clk(core_clk), .arst_n(arst_n), .sys_addr(sys_addr),
    .sys_req(sys_req), .slice_sel_q(slice_sel_q), .slice_miss_q(slice_miss_q), .sys_irq(sys_irq),
    .irq_src_q(irq_src_q), .periph_clk_en_q(periph_clk_en_q), .conv_req(conv_req),
    .func_a_out(func_a_out), .func_a_oe(func_a_oe), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
    .pad_pullup_q(pad_pullup_q));
